// ==== verilog/ilg_mix_ctrl.sv ====
// right line input routing and level for both adc mixers, with power and soft-step control for the right adc only
`timescale 1ns/10ps
`default_nettype none
module ilg_mix_ctrl
    import ilg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // sample rate
    input wire logic fs_tick,
    // left mixer
    output logic left_mix_connect,
    output logic [3:0] left_mix_atten,
    // right mixer and adc
    output logic right_mix_connect,
    output logic [3:0] right_mix_atten,
    output logic right_adc_power_up,
    output logic right_gain_ramping
);

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic ladc_rsvd_r, ladc_rsvd_nxt;
    logic [3:0] ladc_lvl_r, ladc_lvl_nxt;
    logic radc_rsvd_r, radc_rsvd_nxt;
    logic [3:0] radc_lvl_r, radc_lvl_nxt;
    logic radc_pwr_r, radc_pwr_nxt;
    logic [1:0] radc_step_r, radc_step_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb begin
        ladc_rsvd_nxt = ladc_rsvd_r;
        ladc_lvl_nxt = ladc_lvl_r;
        radc_rsvd_nxt = radc_rsvd_r;
        radc_lvl_nxt = radc_lvl_r;
        radc_pwr_nxt = radc_pwr_r;
        radc_step_nxt = radc_step_r;
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd;
        if (reg_wr) begin
            case (reg_addr)
                ILG_OFS_RLINE_TO_LADC: begin
                    ladc_rsvd_nxt = reg_wdata[ILG_RSVD_BIT];
                    // reserved codes are stored as written; the mixer output treats them as disconnected
                    ladc_lvl_nxt = reg_wdata[ILG_LVL_MSB:ILG_LVL_LSB];
                    // low three bits have no storage
                end
                ILG_OFS_RLINE_TO_RADC: begin
                    radc_rsvd_nxt = reg_wdata[ILG_RSVD_BIT];
                    radc_lvl_nxt = reg_wdata[ILG_LVL_MSB:ILG_LVL_LSB];
                    radc_pwr_nxt = reg_wdata[ILG_PWR_BIT];
                    radc_step_nxt = reg_wdata[ILG_STEP_MSB:ILG_STEP_LSB];
                end
                default: ;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                ILG_OFS_RLINE_TO_LADC: rdata_nxt = {ladc_rsvd_r, ladc_lvl_r, 3'h0};
                ILG_OFS_RLINE_TO_RADC: rdata_nxt = {radc_rsvd_r, radc_lvl_r, radc_pwr_r, radc_step_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ladc_rsvd_r <= ILG_RST_RSVD;
            ladc_lvl_r <= ILG_RST_LVL;
            radc_rsvd_r <= ILG_RST_RSVD;
            radc_lvl_r <= ILG_RST_LVL;
            radc_pwr_r <= ILG_RST_PWR;
            radc_step_r <= ILG_RST_STEP;
            rdata_r <= ILG_RST_RDATA;
            rvalid_r <= 1'b0;
        end else begin
            ladc_rsvd_r <= ladc_rsvd_nxt;
            ladc_lvl_r <= ladc_lvl_nxt;
            radc_rsvd_r <= radc_rsvd_nxt;
            radc_lvl_r <= radc_lvl_nxt;
            radc_pwr_r <= radc_pwr_nxt;
            radc_step_r <= radc_step_nxt;
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // soft-step interval divider
    logic half_r, half_nxt;
    logic step_tick;
    logic step_en;

    always_comb begin
        half_nxt = half_r;
        if (fs_tick) begin
            half_nxt = ~half_r;
        end
        step_en = (radc_step_r == ILG_STEP_EVERY_FS) || (radc_step_r == ILG_STEP_EVERY_2FS);
        case (radc_step_r)
            ILG_STEP_EVERY_FS: step_tick = fs_tick;
            ILG_STEP_EVERY_2FS: step_tick = fs_tick && half_r;
            default: step_tick = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            half_r <= 1'b0;
        end else begin
            half_r <= half_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // right path stepper; the left path has no stepping control here
    logic [3:0] right_applied;

    ilg_soft_step u_right_step (
        .clk(clk),
        .sys_rst(sys_rst),
        .target_lvl(radc_lvl_r),
        .step_en(step_en),
        .step_tick(step_tick),
        .applied_lvl(right_applied),
        .ramping(right_gain_ramping)
    );

    ////////////////////////////////////////////////////////////////////////
    // mixer outputs, registered so the analog side sees no decode glitches
    logic lconn_r, lconn_nxt;
    logic [3:0] latt_r, latt_nxt;
    logic rconn_r, rconn_nxt;
    logic [3:0] ratt_r, ratt_nxt;

    always_comb begin
        // reserved codes count as disconnected, the safe side
        lconn_nxt = ilg_is_gain(ladc_lvl_r);
        latt_nxt = lconn_nxt ? ladc_lvl_r : ILG_LVL_OFF;
        rconn_nxt = ilg_is_gain(right_applied);
        ratt_nxt = rconn_nxt ? right_applied : ILG_LVL_OFF;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lconn_r <= 1'b0;
            latt_r <= ILG_LVL_OFF;
            rconn_r <= 1'b0;
            ratt_r <= ILG_LVL_OFF;
        end else begin
            lconn_r <= lconn_nxt;
            latt_r <= latt_nxt;
            rconn_r <= rconn_nxt;
            ratt_r <= ratt_nxt;
        end
    end

    assign left_mix_connect = lconn_r;
    assign left_mix_atten = latt_r;
    assign right_mix_connect = rconn_r;
    assign right_mix_atten = ratt_r;
    assign right_adc_power_up = radc_pwr_r;

endmodule : ilg_mix_ctrl
`default_nettype wire

// ==== common/ilg_pkg.sv ====
// constants for the adc input mix gain control block
package ilg_pkg;

    // register offsets on control page 0
    localparam logic [7:0] ILG_OFS_RLINE_TO_LADC = 8'h15;
    localparam logic [7:0] ILG_OFS_RLINE_TO_RADC = 8'h16;

    // field positions
    localparam int ILG_LVL_MSB = 6;
    localparam int ILG_LVL_LSB = 3;
    localparam int ILG_PWR_BIT = 2;
    localparam int ILG_STEP_MSB = 1;
    localparam int ILG_STEP_LSB = 0;
    localparam int ILG_RSVD_BIT = 7;

    // level codes
    localparam logic [3:0] ILG_LVL_0DB = 4'h0;
    localparam logic [3:0] ILG_LVL_MAX_CUT = 4'h8;
    localparam logic [3:0] ILG_LVL_OFF = 4'hf;

    // soft-step modes
    localparam logic [1:0] ILG_STEP_EVERY_FS = 2'h0;
    localparam logic [1:0] ILG_STEP_EVERY_2FS = 2'h1;

    // reset values
    localparam logic [3:0] ILG_RST_LVL = 4'hf;
    localparam logic ILG_RST_PWR = 1'b0;
    localparam logic [1:0] ILG_RST_STEP = 2'h0;
    localparam logic ILG_RST_RSVD = 1'b0;
    localparam logic [7:0] ILG_RST_RDATA = 8'h00;

    typedef enum logic [1:0] {
        ILG_SS_IDLE = 2'b00,
        ILG_SS_RAMP = 2'b01
    } ilg_ss_state_t;

    // a code drives the mixer only if it is one of the nine gain codes
    function automatic logic ilg_is_gain(input logic [3:0] code);
        ilg_is_gain = (code <= ILG_LVL_MAX_CUT);
    endfunction : ilg_is_gain

endpackage : ilg_pkg

// ==== verilog/ilg_soft_step.sv ====
// gain stepper: walks the applied level code toward its target
`timescale 1ns/10ps
`default_nettype none
module ilg_soft_step
    import ilg_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // control
    input wire logic [3:0] target_lvl,
    input wire logic step_en,
    input wire logic step_tick,
    // applied level
    output logic [3:0] applied_lvl,
    output logic ramping
);

    ilg_ss_state_t state_r, state_nxt;
    logic [3:0] lvl_r, lvl_nxt;

    always_comb begin
        state_nxt = state_r;
        lvl_nxt = lvl_r;
        // connect, disconnect and unstepped writes jump at once; a ramp out of
        // silence would only add a click-free delay with nothing to protect
        if (!step_en || !ilg_is_gain(target_lvl) || !ilg_is_gain(lvl_r)) begin
            lvl_nxt = target_lvl;
            state_nxt = ILG_SS_IDLE;
        end else if (lvl_r == target_lvl) begin
            state_nxt = ILG_SS_IDLE;
        end else begin
            state_nxt = ILG_SS_RAMP;
            if (step_tick) begin
                if (lvl_r < target_lvl) begin
                    lvl_nxt = lvl_r + 4'h1;
                end else begin
                    lvl_nxt = lvl_r - 4'h1;
                end
            end
        end
        case (state_nxt)
            ILG_SS_IDLE: ramping = 1'b0;
            ILG_SS_RAMP: ramping = 1'b1;
            default: ramping = 1'b0;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= ILG_SS_IDLE;
            lvl_r <= ILG_RST_LVL;
        end else begin
            state_r <= state_nxt;
            lvl_r <= lvl_nxt;
        end
    end

    assign applied_lvl = lvl_r;

endmodule : ilg_soft_step
`default_nettype wire

// ==== bench/ilg_adc_model.sv ====
// sample-rate source standing for the converter side
`timescale 1ns/10ps
`default_nettype none
module ilg_adc_model #(
    parameter int FS_DIV = 10
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sample strobe
    output logic fs_tick
);
    logic [7:0] div_r;
    // a short sample period keeps ramps brief; the real rate is far slower
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) div_r <= 8'h00;
        else div_r <= fs_tick ? 8'h00 : div_r + 8'h01;
    end
    assign fs_tick = (div_r == 8'(FS_DIV - 1));
endmodule : ilg_adc_model
`default_nettype wire

// ==== bench/ilg_mix_ctrl_monitor.sv ====
// assertions on the mix gain control ports
`timescale 1ns/10ps
`default_nettype none
module ilg_mix_ctrl_monitor (
    // clock, reset, register port
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    // sample rate and mixers
    input wire logic fs_tick,
    input wire logic left_mix_connect,
    input wire logic [3:0] left_mix_atten,
    input wire logic right_mix_connect,
    input wire logic [3:0] right_mix_atten,
    input wire logic right_adc_power_up,
    input wire logic right_gain_ramping
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic wl = reg_wr && reg_addr == 8'h15;
    wire logic wr16 = reg_wr && reg_addr == 8'h16;
    logic [1:0] mode_r;
    // the register is hidden from us, so the step mode is shadowed here
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) mode_r <= 2'h0;
        else if (wr16) mode_r <= reg_wdata[1:0];
    end
    sequence s_left_gain;
        wl && reg_wdata[6:3] <= 4'h8;
    endsequence
    sequence s_right_jump;
        wr16 && reg_wdata[1] && reg_wdata[6:3] <= 4'h8;
    endsequence
    chk_left_gain: assert property (s_left_gain |=> ##1 left_mix_connect && left_mix_atten == $past(reg_wdata[6:3], 2))
        else $error("left gain not applied");
    chk_left_off: assert property (wl && reg_wdata[6:3] == 4'hf |=> ##1 !left_mix_connect && left_mix_atten == 4'hf)
        else $error("left path not cut");
    chk_left_link: assert property (left_mix_connect == (left_mix_atten <= 4'h8))
        else $error("left connect wrong");
    chk_right_link: assert property (right_mix_connect == (right_mix_atten <= 4'h8))
        else $error("right connect wrong");
    // the stepper adds one register stage ahead of the mixer output stage
    chk_right_jump: assert property (s_right_jump |=> ##2 right_mix_connect && right_mix_atten == $past(reg_wdata[6:3], 3))
        else $error("right gain not applied");
    chk_power_bit: assert property (wr16 ##1 !wr16 |=> right_adc_power_up == $past(reg_wdata[2], 2))
        else $error("power bit wrong");
    chk_step_size: assert property (!mode_r[1] && $changed(right_mix_atten) && right_mix_atten <= 4'h8
        && $past(right_mix_atten) <= 4'h8 |-> $past(fs_tick, 2) && (right_mix_atten - $past(right_mix_atten) == 4'h1
        || $past(right_mix_atten) - right_mix_atten == 4'h1))
        else $error("step not single or untimed");
    chk_read_low: assert property (reg_rd && reg_addr == 8'h15 |=> reg_rvalid && reg_rdata[2:0] == 3'h0)
        else $error("low bits not zero");
endmodule : ilg_mix_ctrl_monitor
`default_nettype wire

// ==== bench/ilg_mix_ctrl_tb.sv ====
// self-checking bench for the mix gain control block
`timescale 1ns/10ps
`default_nettype none
module ilg_mix_ctrl_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic reg_rvalid, fs_tick, left_mix_connect, right_mix_connect, right_adc_power_up, right_gain_ramping;
    logic [3:0] left_mix_atten, right_mix_atten;
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    ilg_mix_ctrl dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .fs_tick(fs_tick),
        .left_mix_connect(left_mix_connect), .left_mix_atten(left_mix_atten), .right_mix_connect(right_mix_connect),
        .right_mix_atten(right_mix_atten), .right_adc_power_up(right_adc_power_up),
        .right_gain_ramping(right_gain_ramping));
    ilg_adc_model #(.FS_DIV(10)) u_adc (.clk(clk), .sys_rst(sys_rst), .fs_tick(fs_tick));
    task automatic summarize();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("rvalid", 8'h01, 8'(reg_rvalid));
        chk("rdata", exp, reg_rdata);
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    // a hang costs a mismatch and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rd(8'h15, 8'h78);
        rd(8'h16, 8'h78);
        rd(8'h20, 8'h00);
        chk("right_pwr", 8'h00, 8'(right_adc_power_up));
        for (int c = 0; c <= 8; c++) begin
            wr(8'h15, {1'b0, 4'(c), 3'h0});
            wr(8'h16, {1'b0, 4'(c), 3'h6});
            settle(2);
            chk("left_att", 8'(c), 8'(left_mix_atten));
            chk("left_con", 8'h01, 8'(left_mix_connect));
            chk("right_att", 8'(c), 8'(right_mix_atten));
            chk("right_con", 8'h01, 8'(right_mix_connect));
            chk("right_pwr", 8'h01, 8'(right_adc_power_up));
            rd(8'h15, {1'b0, 4'(c), 3'h0});
        end
        wr(8'h15, 8'h78);
        wr(8'h16, 8'h06);
        settle(2);
        chk("left_con", 8'h00, 8'(left_mix_connect));
        // ramp up one code per sample, then down one code per two samples
        wr(8'h16, 8'h44);
        settle(45);
        chk("ramping", 8'h01, 8'(right_gain_ramping));
        chk("right_mid", 8'h01, 8'(right_mix_atten inside {[4'h3:4'h5]}));
        settle(60);
        chk("right_att", 8'h08, 8'(right_mix_atten));
        chk("ramping", 8'h00, 8'(right_gain_ramping));
        wr(8'h16, 8'h05);
        settle(90);
        chk("right_mid", 8'h01, 8'(right_mix_atten inside {[4'h3:4'h5]}));
        settle(100);
        chk("right_att", 8'h00, 8'(right_mix_atten));
        // step code 11 with a disconnect, which jumps under any step code
        wr(8'h16, 8'h7b);
        settle(2);
        chk("right_con", 8'h00, 8'(right_mix_connect));
        chk("right_pwr", 8'h00, 8'(right_adc_power_up));
        rd(8'h16, 8'h7b);
        summarize();
    end
endmodule : ilg_mix_ctrl_tb
bind ilg_mix_ctrl ilg_mix_ctrl_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .fs_tick(fs_tick), .left_mix_connect(left_mix_connect), .left_mix_atten(left_mix_atten),
    .right_mix_connect(right_mix_connect), .right_mix_atten(right_mix_atten),
    .right_adc_power_up(right_adc_power_up), .right_gain_ramping(right_gain_ramping));
`default_nettype wire
